/* File: src/pssl_pkg.sv */
package pssl_pkg;

  // ----------------------------------------
  // array variants
  // ----------------------------------------
  localparam int ROWS_LARGE = 18;
  localparam int COLS_LARGE = 82;
  localparam int FILLER_LARGE = 443;
  localparam int FILLER_MID = 361;
  localparam int FILLER_SMALL = 308;
  localparam logic [9:0] CNT_PAT_LARGE = 10'h0df;
  localparam logic [9:0] CNT_PAT_MID = 10'h3c1;
  localparam logic [9:0] CNT_PAT_SMALL = 10'h35a;

  // ----------------------------------------
  // stream layout
  // ----------------------------------------
  localparam int CNT_BITS = 10;
  localparam int MODE_BITS = 21;
  localparam logic [20:0] MODE_PAT_A = 21'h0063e0;
  localparam logic [20:0] MODE_PAT_B = 21'h0053e0;
  localparam logic [20:0] MODE_PAT_AB = 21'h0073e0;
  localparam logic STOP_BIT = 1'b0;

  function automatic int chain_length(int rows, int cols, int filler);
    return CNT_BITS + MODE_BITS + filler + 2 * (rows + cols) + 1;
  endfunction : chain_length

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int PCLK_MHZ = 25;
  localparam int SHIFT_MHZ = 10;
  localparam int SHIFT_HALF_CYC = (PCLK_MHZ + 2 * SHIFT_MHZ - 1) / (2 * SHIFT_MHZ);

  // ----------------------------------------
  // host registers
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SEL_A = 8'h04;
  localparam logic [7:0] REG_SEL_B = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_PROBE_LO = 2;
  localparam int SEL_ROW_LO = 0;
  localparam int SEL_COL_LO = 16;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;

  // ----------------------------------------
  // state types
  // ----------------------------------------
  typedef enum logic [1:0] {
    DEV_USER = 2'b00,
    DEV_SHIFT = 2'b01,
    DEV_CHECK = 2'b11,
    DEV_HOLD = 2'b10
  } pssl_dev_state_t;

  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_LOW = 2'b01,
    HOST_HIGH = 2'b11,
    HOST_DONE = 2'b10
  } pssl_host_state_t;

endpackage : pssl_pkg

/* File: src/pssl_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface pssl_link_if;
  logic mode_pin;
  logic diag_shift_clock;
  logic probe_serial_in;
  logic probe_out_a;
  logic probe_out_a_oe;
  logic probe_out_b;
  logic probe_out_b_oe;

  modport dev (
    input mode_pin, diag_shift_clock, probe_serial_in,
    output probe_out_a, probe_out_a_oe, probe_out_b, probe_out_b_oe
  );
  modport host (
    output mode_pin, diag_shift_clock, probe_serial_in,
    input probe_out_a, probe_out_a_oe, probe_out_b, probe_out_b_oe
  );
endinterface : pssl_link_if
`default_nettype wire

/* File: src/pssl_probe_device.sv */
`timescale 1ns/100ps
`default_nettype none
module pssl_probe_device
  import pssl_pkg::*;
#(
  parameter int ROWS = ROWS_LARGE,
  parameter int COLS = COLS_LARGE,
  parameter int FILLER = FILLER_LARGE,
  parameter logic [9:0] CNT_PAT = CNT_PAT_LARGE
) (
  input wire logic pclk,
  input wire logic presetn,
  pssl_link_if.dev link,
  input wire logic [ROWS*COLS-1:0] node_values,
  input wire logic programmed_ok,
  input wire logic security_fuse_blown,
  input wire logic user_out_a,
  input wire logic user_oe_a,
  input wire logic user_out_b,
  input wire logic user_oe_b,
  output logic user_in_serial,
  output logic user_in_clock,
  output logic probe_a_active,
  output logic probe_b_active
);

  localparam int TOTAL = chain_length(ROWS, COLS, FILLER);
  localparam int CW = $clog2(TOTAL + 1);
  localparam logic [CW-1:0] LAST = CW'(TOTAL - 1);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] mode_sync;
  logic [2:0] clk_sync;
  logic [2:0] data_sync;
  logic mode_f;
  logic clk_f;
  logic data_f;
  logic clk_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_sync <= 3'h0;
      clk_sync <= 3'h0;
      data_sync <= 3'h0;
    end else begin
      mode_sync <= {mode_sync[1:0], link.mode_pin};
      clk_sync <= {clk_sync[1:0], link.diag_shift_clock};
      data_sync <= {data_sync[1:0], link.probe_serial_in};
    end
  end

  // a level only counts once two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_f <= 1'b0;
      clk_f <= 1'b0;
      data_f <= 1'b0;
    end else begin
      if (mode_sync[1] == mode_sync[2]) begin
        mode_f <= mode_sync[2];
      end
      if (clk_sync[1] == clk_sync[2]) begin
        clk_f <= clk_sync[2];
      end
      if (data_sync[1] == data_sync[2]) begin
        data_f <= data_sync[2];
      end
    end
  end

  assign clk_rise = (clk_sync[1] == clk_sync[2]) && clk_sync[2] && !clk_f;

  // ----------------------------------------
  // load sequence
  // ----------------------------------------
  pssl_dev_state_t state;
  logic [TOTAL-1:0] chain;
  logic [CW-1:0] count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= DEV_USER;
    end else if (!mode_f) begin
      state <= DEV_USER;
    end else begin
      case (state)
        DEV_USER: begin
          state <= DEV_SHIFT;
        end
        DEV_SHIFT: begin
          if (clk_rise && count == LAST) begin
            state <= DEV_CHECK;
          end
        end
        DEV_CHECK: begin
          state <= DEV_HOLD;
        end
        DEV_HOLD: begin
          state <= DEV_HOLD;
        end
        default: begin
          state <= DEV_USER;
        end
      endcase
    end
  end

  // one long chain, new bits enter at bit 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain <= '0;
      count <= '0;
    end else if (!mode_f) begin
      count <= '0;
    end else if ((state == DEV_USER || state == DEV_SHIFT) && clk_rise) begin
      // mode and first clock settle only a cycle apart, so take that rise too
      chain <= {chain[TOTAL-2:0], data_f};
      count <= count + CW'(1);
    end
  end

  // ----------------------------------------
  // field extraction
  // ----------------------------------------
  // the first bit sent ends at the top of the chain
  logic [CNT_BITS-1:0] cnt_field;
  logic [MODE_BITS-1:0] mode_field;
  logic [ROWS-1:0] rows_a;
  logic [ROWS-1:0] rows_b;
  logic [COLS-1:0] cols_a;
  logic [COLS-1:0] cols_b;

  assign cnt_field = chain[TOTAL-1 -: CNT_BITS];
  assign mode_field = chain[TOTAL-1-CNT_BITS -: MODE_BITS];

  for (genvar r = 0; r < ROWS; r++) begin : g_rows
    assign rows_a[r] = chain[1 + COLS + (ROWS - 1 - r)];
    assign rows_b[r] = chain[1 + 2 * COLS + ROWS + (ROWS - 1 - r)];
  end

  for (genvar c = 0; c < COLS; c++) begin : g_cols
    assign cols_a[c] = chain[1 + (COLS - 1 - c)];
    assign cols_b[c] = chain[1 + COLS + ROWS + c];
  end

  // ----------------------------------------
  // selection latch
  // ----------------------------------------
  logic [ROWS-1:0] row_select_a;
  logic [ROWS-1:0] row_select_b;
  logic [COLS-1:0] col_select_a;
  logic [COLS-1:0] col_select_b;
  logic access_ok;
  logic stream_ok;
  logic want_a;
  logic want_b;

  // access is judged once, in DEV_CHECK: a part secured or unprogrammed at that point exposes no nodes
  assign access_ok = programmed_ok && !security_fuse_blown;
  // filler is not checked: a wrong count already breaks the counter field
  assign stream_ok = (cnt_field == CNT_PAT);
  assign want_a = (mode_field == MODE_PAT_A) ||
                  (mode_field == MODE_PAT_AB);
  assign want_b = (mode_field == MODE_PAT_B) ||
                  (mode_field == MODE_PAT_AB);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_select_a <= '0;
      row_select_b <= '0;
      col_select_a <= '0;
      col_select_b <= '0;
      probe_a_active <= 1'b0;
      probe_b_active <= 1'b0;
    end else if (state == DEV_USER) begin
      probe_a_active <= 1'b0;
      probe_b_active <= 1'b0;
    end else if (state == DEV_CHECK) begin
      row_select_a <= rows_a;
      col_select_a <= cols_a;
      row_select_b <= rows_b;
      col_select_b <= cols_b;
      probe_a_active <= access_ok && stream_ok && want_a &&
                        $onehot(rows_a) && $onehot(cols_a);
      probe_b_active <= access_ok && stream_ok && want_b &&
                        $onehot(rows_b) && $onehot(cols_b);
    end
  end

  function automatic logic pick_node(input logic [ROWS-1:0] rsel,
                                     input logic [COLS-1:0] csel,
                                     input logic [ROWS*COLS-1:0] nodes);
    logic v;
    v = 1'b0;
    for (int r = 0; r < ROWS; r++) begin
      for (int c = 0; c < COLS; c++) begin
        v = v | (rsel[r] & csel[c] & nodes[r*COLS+c]);
      end
    end
    return v;
  endfunction : pick_node

  // ----------------------------------------
  // pin outputs
  // ----------------------------------------
  // one flop after the latch, far below the pin delay of the real part
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.probe_out_a <= 1'b0;
      link.probe_out_a_oe <= 1'b0;
      link.probe_out_b <= 1'b0;
      link.probe_out_b_oe <= 1'b0;
    end else if (!mode_f) begin
      link.probe_out_a <= user_out_a;
      link.probe_out_a_oe <= user_oe_a;
      link.probe_out_b <= user_out_b;
      link.probe_out_b_oe <= user_oe_b;
    end else begin
      link.probe_out_a <= probe_a_active &&
        pick_node(row_select_a, col_select_a, node_values);
      link.probe_out_a_oe <= probe_a_active;
      link.probe_out_b <= probe_b_active &&
        pick_node(row_select_b, col_select_b, node_values);
      link.probe_out_b_oe <= probe_b_active;
    end
  end

  // user logic sees the pins only in user mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      user_in_serial <= 1'b0;
      user_in_clock <= 1'b0;
    end else begin
      user_in_serial <= !mode_f && data_f;
      user_in_clock <= !mode_f && clk_f;
    end
  end

endmodule : pssl_probe_device
`default_nettype wire

/* File: src/pssl_probe_host.sv */
`timescale 1ns/100ps
`default_nettype none
module pssl_probe_host
  import pssl_pkg::*;
#(
  parameter int ROWS = ROWS_LARGE,
  parameter int COLS = COLS_LARGE,
  parameter int FILLER = FILLER_LARGE,
  parameter logic [9:0] CNT_PAT = CNT_PAT_LARGE,
  parameter int HALF_CYC = SHIFT_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  pssl_link_if.host link
);

  localparam int TOTAL = chain_length(ROWS, COLS, FILLER);
  localparam int CW = $clog2(TOTAL + 1);
  localparam logic [CW-1:0] LAST = CW'(TOTAL - 1);
  localparam logic [7:0] HALF = 8'(HALF_CYC - 1);

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  logic [31:0] ctrl;
  logic [31:0] sel_a;
  logic [31:0] sel_b;
  logic wr_now;
  logic start_req;
  pssl_host_state_t state;

  assign wr_now = psel && penable && pready && pwrite;
  assign start_req = wr_now && paddr == REG_CTRL && pwdata[CTRL_START] &&
                     pwdata[CTRL_ENABLE] &&
                     (state == HOST_IDLE || state == HOST_DONE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= !(paddr == REG_CTRL || paddr == REG_SEL_A ||
                   paddr == REG_SEL_B || paddr == REG_STATUS);
      case (paddr)
        REG_CTRL: prdata <= ctrl;
        REG_SEL_A: prdata <= sel_a;
        REG_SEL_B: prdata <= sel_b;
        REG_STATUS: prdata <= {30'h0, state == HOST_DONE,
                               state == HOST_LOW || state == HOST_HIGH};
        default: prdata <= 32'h0000_0000;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // start reads back as zero; selections can be written in any state, even during a load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      sel_a <= SEL_RESET;
      sel_b <= SEL_RESET;
    end else if (wr_now) begin
      case (paddr)
        REG_CTRL: ctrl <= {28'h0, pwdata[3:2], 1'b0, pwdata[0]};
        REG_SEL_A: sel_a <= pwdata;
        REG_SEL_B: sel_b <= pwdata;
        default: ctrl <= ctrl;
      endcase
    end
  end

  // ----------------------------------------
  // stream generation
  // ----------------------------------------
  function automatic logic stream_bit(input logic [CW-1:0] idx,
                                      input logic [1:0] probes,
                                      input logic [31:0] sa,
                                      input logic [31:0] sb);
    int i;
    int base;
    logic [20:0] mp;
    i = int'(idx);
    base = CNT_BITS + MODE_BITS + FILLER;
    mp = probes == 2'h1 ? MODE_PAT_A :
         probes == 2'h2 ? MODE_PAT_B : MODE_PAT_AB;
    if (i < CNT_BITS) begin
      return CNT_PAT[CNT_BITS-1-i];
    end else if (i < CNT_BITS + MODE_BITS) begin
      return mp[MODE_BITS-1-(i-CNT_BITS)];
    end else if (i < base) begin
      return 1'b0;
    end else if (i < base + ROWS) begin
      return int'(sb[15:0]) == i - base;
    end else if (i < base + ROWS + COLS) begin
      return int'(sb[31:16]) == COLS - 1 - (i - base - ROWS);
    end else if (i < base + 2 * ROWS + COLS) begin
      return int'(sa[15:0]) == i - base - ROWS - COLS;
    end else if (i < base + 2 * (ROWS + COLS)) begin
      return int'(sa[31:16]) == i - base - 2 * ROWS - COLS;
    end
    return STOP_BIT;
  endfunction : stream_bit

  logic [CW-1:0] idx;
  logic [7:0] tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= HOST_IDLE;
      idx <= '0;
      tick <= 8'h00;
      link.mode_pin <= 1'b0;
      link.diag_shift_clock <= 1'b0;
      link.probe_serial_in <= 1'b0;
    end else begin
      link.mode_pin <= ctrl[CTRL_ENABLE];
      // enable and start may land in one write: start goes first
      if (start_req) begin
        state <= HOST_LOW;
        idx <= '0;
        tick <= 8'h00;
        link.diag_shift_clock <= 1'b0;
        link.probe_serial_in <= stream_bit('0, pwdata[3:2], sel_a, sel_b);
      end else if (!ctrl[CTRL_ENABLE]) begin
        state <= HOST_IDLE;
        link.diag_shift_clock <= 1'b0;
        link.probe_serial_in <= 1'b0;
      end else begin
        case (state)
          HOST_LOW: begin
            tick <= tick + 8'h01;
            if (tick == HALF) begin
              tick <= 8'h00;
              state <= HOST_HIGH;
              link.diag_shift_clock <= 1'b1;
            end
          end
          HOST_HIGH: begin
            tick <= tick + 8'h01;
            if (tick == HALF) begin
              tick <= 8'h00;
              if (idx == LAST) begin
                state <= HOST_DONE;
              end else begin
                state <= HOST_LOW;
                idx <= idx + CW'(1);
                link.diag_shift_clock <= 1'b0;
                link.probe_serial_in <= stream_bit(idx + CW'(1),
                  ctrl[3:2], sel_a, sel_b);
              end
            end
          end
          HOST_IDLE: state <= HOST_IDLE;
          HOST_DONE: state <= HOST_DONE;
          default: state <= HOST_IDLE;
        endcase
      end
    end
  end

endmodule : pssl_probe_host
`default_nettype wire

/* File: bench/pssl_link_props.sv */
`timescale 1ns/100ps
`default_nettype none
module pssl_link_props #(
  parameter int TOTAL = 675
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mode_pin,
  input wire logic diag_shift_clock,
  input wire logic probe_serial_in,
  input wire logic probe_out_a,
  input wire logic probe_out_a_oe,
  input wire logic probe_out_b,
  input wire logic probe_out_b_oe
);
  // ----------------------------------------
  // edge bookkeeping
  // ----------------------------------------
  logic clk_q;
  logic [15:0] edge_cnt;
  logic [3:0] done_cyc;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_q <= 1'b0;
    end else begin
      clk_q <= diag_shift_clock;
    end
  end

  // counts pin edges, not device-seen edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_cnt <= 16'h0000;
    end else if (!mode_pin) begin
      edge_cnt <= 16'h0000;
    end else if (diag_shift_clock && !clk_q && edge_cnt != 16'hffff) begin
      edge_cnt <= edge_cnt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_cyc <= 4'h0;
    end else if (!mode_pin || edge_cnt != 16'(TOTAL)) begin
      done_cyc <= 4'h0;
    end else if (done_cyc != 4'hf) begin
      done_cyc <= done_cyc + 4'h1;
    end
  end

  // ----------------------------------------
  // link checks
  // ----------------------------------------
  a_mode_before_clk: assert property (
    $rose(diag_shift_clock) |-> mode_pin && $past(mode_pin))
    else $error("clock rose without mode high");
  a_clk_level_len: assert property (
    mode_pin && $changed(diag_shift_clock)
    |=> $stable(diag_shift_clock) || !mode_pin)
    else $error("clock level shorter than two cycles");
  a_sdi_hold_high: assert property (
    mode_pin && diag_shift_clock && $past(diag_shift_clock)
    |-> $stable(probe_serial_in))
    else $error("serial data moved while clock high");
  a_edge_count_max: assert property (
    edge_cnt <= 16'(TOTAL))
    else $error("too many clock edges in one load");
  a_clk_stop_high: assert property (
    mode_pin && edge_cnt == 16'(TOTAL) |-> diag_shift_clock)
    else $error("clock not left high after stop bit");
  a_quiet_while_load: assert property (
    edge_cnt >= 16'h0002 && edge_cnt < 16'(TOTAL)
    |-> !probe_out_a_oe && !probe_out_b_oe)
    else $error("probe pin driven during load");
  a_hold_sel: assert property (
    done_cyc >= 4'hc |-> $stable(probe_out_a_oe) && $stable(probe_out_b_oe))
    else $error("probe selection not held");
  a_off_drives_zero: assert property (
    done_cyc >= 4'hc |-> (probe_out_a_oe || !probe_out_a)
    && (probe_out_b_oe || !probe_out_b))
    else $error("inactive probe not low");

  c_load_done: cover property (done_cyc == 4'h1);
  c_probe_a: cover property (done_cyc >= 4'hc && probe_out_a_oe);
  c_probe_b: cover property (done_cyc >= 4'hc && probe_out_b_oe);
  c_none: cover property (done_cyc >= 4'hc && !probe_out_a_oe && !probe_out_b_oe);
endmodule : pssl_link_props
`default_nettype wire

/* File: bench/tb_probe_serial_select_loader.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_probe_serial_select_loader
  import pssl_pkg::*;
  ;
  localparam int R = 4;
  localparam int C = 5;
  localparam int FILL = 8;
  localparam int TOTAL = CNT_BITS + MODE_BITS + FILL + 2 * (R + C) + 1;
  typedef struct packed {
    logic [3:0] ra, ca, rb, cb;
    logic [1:0] pr;
    logic ea, eb;
  } pssl_case_t;
  // row 4 has an out-of-range row, so its field is all zero
  pssl_case_t rows [5] = '{20'h12346, 20'h00349, 20'h2104f, 20'h30133,
                           20'h4022d};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er;
  logic [R*C-1:0] node = 20'h5a3c6;
  logic prog = 1'b1;
  logic fuse = 1'b0;
  logic uoa = 1'b0, uea = 1'b0, uob = 1'b0, ueb = 1'b0;
  logic uis, uic, act_a, act_b, clk_q = 1'b0;
  logic cap [$];
  int fail_count = 0;
  int cmp_count = 0;

  pssl_link_if lk ();
  pssl_probe_device #(.ROWS(R), .COLS(C), .FILLER(FILL))
    pssl_probe_device_inst (.pclk(pclk), .presetn(presetn), .link(lk),
    .node_values(node), .programmed_ok(prog), .security_fuse_blown(fuse),
    .user_out_a(uoa), .user_oe_a(uea), .user_out_b(uob), .user_oe_b(ueb),
    .user_in_serial(uis), .user_in_clock(uic), .probe_a_active(act_a),
    .probe_b_active(act_b));
  pssl_probe_host #(.ROWS(R), .COLS(C), .FILLER(FILL))
    pssl_probe_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lk));
  pssl_link_props #(.TOTAL(TOTAL)) pssl_link_props_inst (.pclk(pclk),
    .presetn(presetn), .mode_pin(lk.mode_pin),
    .diag_shift_clock(lk.diag_shift_clock),
    .probe_serial_in(lk.probe_serial_in), .probe_out_a(lk.probe_out_a),
    .probe_out_a_oe(lk.probe_out_a_oe), .probe_out_b(lk.probe_out_b),
    .probe_out_b_oe(lk.probe_out_b_oe));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    forever #20 pclk = ~pclk;
  end

  // grabs the wire stream at each rising pin edge
  always @(posedge pclk) begin
    clk_q <= lk.diag_shift_clock;
    if (!lk.mode_pin) cap.delete();
    else if (lk.diag_shift_clock && !clk_q) cap.push_back(lk.probe_serial_in);
  end

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task automatic chk(input logic [32:0] got, input logic [32:0] exp,
                     input string m);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n, 1, "access latency");
  endtask : apb

  task automatic check_stream(input pssl_case_t c);
    logic [20:0] m;
    logic e [$];
    m = (c.pr == 2'h1) ? MODE_PAT_A : (c.pr == 2'h2) ? MODE_PAT_B : MODE_PAT_AB;
    for (int k = 9; k >= 0; k--) e.push_back(CNT_PAT_LARGE[k]);
    for (int k = 20; k >= 0; k--) e.push_back(m[k]);
    repeat (FILL) e.push_back(1'b0);
    for (int k = 0; k < R; k++) e.push_back(k == c.rb);
    for (int k = C - 1; k >= 0; k--) e.push_back(k == c.cb);
    for (int k = 0; k < R; k++) e.push_back(k == c.ra);
    for (int k = 0; k < C; k++) e.push_back(k == c.ca);
    e.push_back(STOP_BIT);
    chk(cap.size(), TOTAL, "edge count");
    for (int k = 0; k < TOTAL && k < cap.size(); k++) begin
      chk(cap[k], e[k], "stream bit");
    end
  endtask : check_stream

  task automatic run_load(input pssl_case_t c, input logic ea,
                          input logic eb);
    apb(1'b1, REG_SEL_A, {12'h000, c.ca, 12'h000, c.ra}, rd, er);
    apb(1'b1, REG_SEL_B, {12'h000, c.cb, 12'h000, c.rb}, rd, er);
    apb(1'b0, REG_SEL_A, 32'h0000_0000, rd, er);
    chk(rd, {12'h000, c.ca, 12'h000, c.ra}, "select readback");
    apb(1'b1, REG_CTRL, {28'h0000000, c.pr, 2'h3}, rd, er);
    do begin
      apb(1'b0, REG_STATUS, 32'h0000_0000, rd, er);
    end while (rd[STAT_DONE] !== 1'b1);
    repeat (12) @(posedge pclk);
    check_stream(c);
    chk({uis, uic}, 0, "user inputs not gated");
    // the node flip shows that the pins follow the node live
    for (int p = 0; p < 2; p++) begin
      chk({act_a, lk.probe_out_a_oe}, {ea, ea}, "a state");
      chk(lk.probe_out_a, ea & node[c.ra*C+c.ca], "a out");
      chk({act_b, lk.probe_out_b_oe}, {eb, eb}, "b state");
      chk(lk.probe_out_b, eb & node[c.rb*C+c.cb], "b out");
      node <= ~node;
      repeat (4) @(posedge pclk);
    end
    apb(1'b1, REG_CTRL, 32'h0000_0000, rd, er);
    repeat (8) @(posedge pclk);
    chk({act_a, act_b, lk.probe_out_a_oe}, {2'h0, uea}, "exit");
  endtask : run_load

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0000_0000, rd, er);
      chk({er, rd}, 0, "reset value");
    end
    apb(1'b1, 8'h10, 32'hffff_ffff, rd, er);
    chk(er, 1, "unmapped write accepted");
    apb(1'b0, 8'h10, 32'h0000_0000, rd, er);
    chk({er, rd}, {1'b1, 32'h0000_0000}, "unmapped read");
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      {uoa, uea, uob, ueb} <= i ? 4'h5 : 4'hf;
      repeat (8) @(posedge pclk);
      chk({lk.probe_out_a, lk.probe_out_a_oe, lk.probe_out_b,
           lk.probe_out_b_oe}, i ? 4'h5 : 4'hf, "user pins");
    end
    foreach (rows[i]) run_load(rows[i], rows[i].ea, rows[i].eb);
    @(posedge pclk);
    prog <= 1'b0;
    run_load(rows[2], 1'b0, 1'b0);
    @(posedge pclk);
    prog <= 1'b1;
    fuse <= 1'b1;
    run_load(rows[2], 1'b0, 1'b0);
    @(posedge pclk);
    fuse <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h0000_0007, rd, er);
    repeat (40) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(lk.mode_pin, 0, "mode after reset");
    apb(1'b0, REG_STATUS, 32'h0000_0000, rd, er);
    chk(rd, 0, "status after reset");
    run_load(rows[2], 1'b1, 1'b1);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    conclude();
  end
endmodule : tb_probe_serial_select_loader
`default_nettype wire
